// File: verilog/opmode_map.vh
/*
  constants of the operating-mode controller: mode codes, timing figures
  and cycle counts at the 40 mhz logic clock.
  assumes inclusion by bare name from the design files.
*/
`ifndef OPMODE_MAP_VH
`define OPMODE_MAP_VH
// logic clock rate in kHz
`define CLK_KHZ 40000
// sleep entry margin after cross conduction, in ns
`define SLEEP_MARGIN_NS 3000
`define SLEEP_MARGIN_CYC ((`SLEEP_MARGIN_NS * `CLK_KHZ + 999999) / 1000000)
// activate low filter time, in ns (longest time, rounds down)
`define ACT_FILT_NS 8000
`define ACT_FILT_CYC ((`ACT_FILT_NS * `CLK_KHZ) / 1000000)
// spi setup delay after activate rises, in ns (choice)
`define SETUP_NS 10000
`define SETUP_CYC ((`SETUP_NS * `CLK_KHZ + 999999) / 1000000)
// frame kinds on frame_kind
`define FK_READ 2'h0
`define FK_WRITE 2'h1
`define FK_CLEAR 2'h2
// mode codes on mode output
`define MODE_SLEEP 3'h1
`define MODE_NORMAL 3'h2
`define MODE_FAILSAFE 3'h4
// reset values
`define CTRL_RESET 16'h0000
`define SENSE_RESET 8'h00
`endif

// File: verilog/event_timer.v
/*
  down counter loaded with a cycle count, flags done when it reaches zero.
  assumes one clock and a synchronous active low reset.
*/
`timescale 1ns/100ps
module event_timer #(
  parameter W = 16
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // control
  input wire load,
  input wire [W-1:0] count,
  input wire run,
  // status
  output reg done
);
  reg [W-1:0] cnt; // remaining cycles

  // load wins over counting; done holds while idle at zero
  always @(posedge clk_sys) begin
    if (!nrst) begin
      cnt <= {W{1'b0}};
      done <= 1'b0;
    end else if (load) begin
      cnt <= count;
      done <= 1'b0;
    end else if (run && cnt != {W{1'b0}}) begin
      cnt <= cnt - {{(W-1){1'b0}}, 1'b1};
      done <= (cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// File: verilog/operating_mode_controller.v
/*
  operating-mode controller: sleep, normal and fail safe modes of a gate
  driver, exit sequence checking, control register freeze and status flags.
  assumes an spi front end that delivers decoded frames as one-cycle
  strobes on clk_sys, and an activate pin from outside the clock domain.
*/
`timescale 1ns/100ps
`include "opmode_map.vh"
// Contract
// - normal only after activate high and setup
// - normal mode enables drivers, accepts configuration
// - activate low delays sleep, active turn-off
// - sleep resets every register
// - sleep enables gate pull-down paths
// - short activate low pulse is filtered
// - frames ignored during sleep-entry delay
// - watchdog error: failsafe flag, active discharge
// - then passive discharge, latched off, pump off
// - failsafe freezes control except toggle, sense
// - failsafe discards other writes, sets error
// - failsafe clear keeps failure flags
// - reads before exit sequence raise no error
// - stray frame during sequence restarts it
// - pump undervoltage set; clear again afterwards
// - state kept across battery supply drops
// - reset reported by por flag zero
// - status clear sets por flag to one
module operating_mode_controller #(
  parameter CCT_W = 12
) (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // activate pin, asynchronous
  input wire activate_pin,
  // supplies in range
  input wire battery_ok,
  input wire logic_supply_ok,
  // cross conduction time of active bridges, in cycles
  input wire [CCT_W-1:0] cross_conduction_time,
  // decoded spi frame strobe
  input wire frame_valid,
  input wire [1:0] frame_kind,
  input wire frame_is_toggle,
  input wire frame_toggle_value,
  input wire frame_is_status,
  input wire frame_is_sense,
  input wire [15:0] frame_ctrl_data,
  input wire [7:0] frame_sense_data,
  // watchdog error pulse and pump undervoltage event
  input wire watchdog_error,
  input wire pump_uv_event,
  // mode and driver controls
  output reg [2:0] mode,
  output reg drivers_enable,
  output reg active_discharge,
  output reg passive_discharge,
  output reg gate_pulldown_resistor,
  output reg pump_enable,
  output reg regulator_enable,
  output reg frames_accepted,
  // register contents and flags
  output reg [15:0] general_control_one,
  output reg watchdog_toggle_bit,
  output reg [7:0] sense_config,
  output reg failsafe_flag,
  output reg serial_error_flag,
  output reg pump_undervoltage_flag,
  output reg power_on_reset_n_flag
);
  // integer figures first, then cut to the counter width on purpose
  localparam integer MARGIN_N = `SLEEP_MARGIN_CYC;
  localparam integer FILT_N = `ACT_FILT_CYC;
  localparam integer SETUP_N = `SETUP_CYC;
  localparam [CCT_W-1:0] MARGIN = MARGIN_N[CCT_W-1:0];
  localparam [CCT_W-1:0] FILT = FILT_N[CCT_W-1:0];
  localparam [CCT_W-1:0] SETUP = SETUP_N[CCT_W-1:0];
  // one-hot states
  localparam [5:0] S_SLEEP = 6'h01;
  localparam [5:0] S_SETUP = 6'h02;
  localparam [5:0] S_NORMAL = 6'h04;
  localparam [5:0] S_DELAY = 6'h08;
  localparam [5:0] S_FS_ACT = 6'h10;
  localparam [5:0] S_FS_PAS = 6'h20;
  // exit sequence progress
  localparam [1:0] X_IDLE = 2'h0;
  localparam [1:0] X_CLR = 2'h1;
  localparam [1:0] X_ONE = 2'h2;

  reg act_meta; // first sync stage, read only by act_sync
  reg act_sync;
  reg [5:0] state;
  reg [5:0] next_state;
  reg [CCT_W-1:0] low_cnt; // filter counter
  reg act_filt; // filtered activate level
  reg [1:0] exit_step;
  reg tmr_load;
  reg [CCT_W-1:0] tmr_count;
  wire tmr_done;
  wire in_fs;
  wire wr_ok;

  // two flop synchroniser for the pin
  always @(posedge clk_sys) begin
    if (!nrst) begin
      act_meta <= 1'b0;
      act_sync <= 1'b0;
    end else begin
      act_meta <= activate_pin;
      act_sync <= act_meta;
    end
  end

  // glitch filter: low must last the filter time to count
  always @(posedge clk_sys) begin
    if (!nrst) begin
      low_cnt <= {CCT_W{1'b0}};
      act_filt <= 1'b0;
    end else if (act_sync) begin
      low_cnt <= {CCT_W{1'b0}};
      act_filt <= 1'b1;
    end else if (low_cnt >= FILT - 1'b1) begin
      act_filt <= 1'b0;
    end else begin
      low_cnt <= low_cnt + 1'b1;
    end
  end

  event_timer #(.W(CCT_W)) u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .load(tmr_load),
    .count(tmr_count),
    .run(1'b1),
    .done(tmr_done)
  );

  assign in_fs = (state == S_FS_ACT) || (state == S_FS_PAS);
  // writes accepted only in normal mode with frames open
  assign wr_ok = frame_valid && (state == S_NORMAL);

  // mode transitions and timer loads
  always @* begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_count = {CCT_W{1'b0}};
    case (state)
      S_SLEEP: begin
        if (act_filt) begin
          next_state = S_SETUP;
          tmr_load = 1'b1;
          tmr_count = SETUP;
        end
      end
      S_SETUP: begin
        if (!act_filt) begin
          next_state = S_SLEEP;
        end else if (tmr_done) begin
          next_state = S_NORMAL;
        end
      end
      S_NORMAL: begin
        if (!act_filt) begin
          next_state = S_DELAY;
          tmr_load = 1'b1;
          tmr_count = cross_conduction_time + MARGIN;
        end else if (watchdog_error) begin
          next_state = S_FS_ACT;
          tmr_load = 1'b1;
          tmr_count = cross_conduction_time;
        end
      end
      S_DELAY: begin
        if (tmr_done) begin
          next_state = S_SLEEP;
        end
      end
      S_FS_ACT: begin
        if (!act_filt) begin
          next_state = S_DELAY;
          tmr_load = 1'b1;
          tmr_count = cross_conduction_time + MARGIN;
        end else if (tmr_done) begin
          next_state = S_FS_PAS;
        end
      end
      S_FS_PAS: begin
        if (!act_filt) begin
          next_state = S_DELAY;
          tmr_load = 1'b1;
          tmr_count = MARGIN;
        end else if (frame_valid && exit_step == X_ONE && frame_kind == `FK_WRITE &&
                     frame_is_toggle && !frame_toggle_value) begin
          next_state = S_NORMAL;
        end
      end
      default: next_state = S_SLEEP;
    endcase
  end

  // state register; logic reset only via nrst, never battery loss
  always @(posedge clk_sys) begin
    if (!nrst) begin
      state <= S_SLEEP;
    end else begin
      state <= next_state;
    end
  end

  // exit sequence tracker in passive fail safe
  always @(posedge clk_sys) begin
    if (!nrst || state != S_FS_PAS) begin
      exit_step <= X_IDLE;
    end else if (frame_valid) begin
      if (frame_kind == `FK_CLEAR && frame_is_status) begin
        exit_step <= X_CLR;
      end else if (exit_step == X_CLR && frame_kind == `FK_WRITE &&
                   frame_is_toggle && frame_toggle_value) begin
        exit_step <= X_ONE;
      end else if (exit_step != X_IDLE) begin
        exit_step <= X_IDLE;
      end
    end
  end

  // registers and flags; sleep returns everything to reset values
  always @(posedge clk_sys) begin
    if (!nrst || state == S_SLEEP) begin
      general_control_one <= `CTRL_RESET;
      watchdog_toggle_bit <= 1'b0;
      sense_config <= `SENSE_RESET;
      failsafe_flag <= 1'b0;
      serial_error_flag <= 1'b0;
      pump_undervoltage_flag <= 1'b0;
      power_on_reset_n_flag <= 1'b0;
    end else begin
      if (in_fs) begin
        general_control_one <= `CTRL_RESET;
      end else if (wr_ok && frame_kind == `FK_WRITE && !frame_is_toggle &&
                   !frame_is_sense) begin
        general_control_one <= frame_ctrl_data;
      end
      // toggle and sense fields stay writable in fail safe
      if ((wr_ok || (in_fs && frame_valid)) && frame_kind == `FK_WRITE) begin
        if (frame_is_toggle) begin
          watchdog_toggle_bit <= frame_toggle_value;
        end
        if (frame_is_sense) begin
          sense_config <= frame_sense_data;
        end
      end
      // status clear: failure flags kept in fail safe; events win
      // clears only count where frames are taken: not in setup or sleep entry
      if (frame_valid && (in_fs || state == S_NORMAL) && frame_kind == `FK_CLEAR &&
          frame_is_status) begin
        power_on_reset_n_flag <= 1'b1;
        if (!in_fs) begin
          serial_error_flag <= 1'b0;
          failsafe_flag <= 1'b0;
          if (!pump_uv_event) begin
            pump_undervoltage_flag <= 1'b0;
          end
        end
      end
      if (state == S_FS_ACT || state == S_FS_PAS) begin
        failsafe_flag <= 1'b1;
        pump_undervoltage_flag <= 1'b1;
      end else if (pump_uv_event) begin
        pump_undervoltage_flag <= 1'b1;
      end
      // discarded write or clear in fail safe flags an error
      if (in_fs && frame_valid &&
          ((frame_kind == `FK_WRITE && !frame_is_toggle && !frame_is_sense) ||
           (frame_kind == `FK_CLEAR && !frame_is_status))) begin
        serial_error_flag <= 1'b1;
      end else if (in_fs && frame_valid && frame_kind == `FK_READ && exit_step != X_IDLE) begin
        serial_error_flag <= 1'b1;
      end
    end
  end

  // driver controls registered from next_state
  always @(posedge clk_sys) begin
    if (!nrst) begin
      mode <= `MODE_SLEEP;
      drivers_enable <= 1'b0;
      active_discharge <= 1'b0;
      passive_discharge <= 1'b1;
      gate_pulldown_resistor <= 1'b1;
      pump_enable <= 1'b0;
      regulator_enable <= 1'b0;
      frames_accepted <= 1'b0;
    end else begin
      // sleep entry delay keeps the mode it came from; sleep starts after it
      mode <= (next_state == S_DELAY) ? mode :
              (next_state == S_NORMAL) ? `MODE_NORMAL :
              ((next_state == S_FS_ACT || next_state == S_FS_PAS) ? `MODE_FAILSAFE :
              `MODE_SLEEP);
      // pump undervoltage keeps drivers off until a clear
      drivers_enable <= (next_state == S_NORMAL) && battery_ok && logic_supply_ok &&
                        !pump_undervoltage_flag;
      active_discharge <= (next_state == S_DELAY) || (next_state == S_FS_ACT);
      passive_discharge <= (next_state == S_FS_PAS) || (next_state == S_SLEEP);
      gate_pulldown_resistor <= (next_state == S_SLEEP);
      pump_enable <= (next_state == S_NORMAL) || (next_state == S_SETUP);
      regulator_enable <= (next_state != S_SLEEP);
      frames_accepted <= (next_state != S_DELAY) && (next_state != S_SLEEP) &&
                         (next_state != S_SETUP);
    end
  end
endmodule

// File: test/opmode_sva.sv
/* checker of the operating-mode controller, ports only.
   assumes opmode_map.vh on the include path and a bind at the foot. */
`timescale 1ns/100ps
`include "opmode_map.vh"
module opmode_sva (
  // clock and reset
  input wire clk_sys,
  input wire nrst,
  // pin and frames
  input wire activate_pin,
  input wire frame_valid,
  input wire [1:0] frame_kind,
  input wire frame_is_toggle,
  input wire frame_is_status,
  input wire frame_is_sense,
  input wire watchdog_error,
  // watched outputs
  input wire [2:0] mode,
  input wire drivers_enable,
  input wire active_discharge,
  input wire passive_discharge,
  input wire gate_pulldown_resistor,
  input wire pump_enable,
  input wire regulator_enable,
  input wire frames_accepted,
  input wire [15:0] general_control_one,
  input wire [7:0] sense_config,
  input wire failsafe_flag,
  input wire serial_error_flag,
  input wire pump_undervoltage_flag,
  input wire power_on_reset_n_flag
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // longest active discharge the bench can configure, with margin
  localparam int FS_MAX = 300;
  reg [15:0] low_cnt;
  reg [15:0] hi_cnt;
  // a write to a plain control field
  wire wr_other = frame_valid && frame_kind == `FK_WRITE && !frame_is_toggle && !frame_is_sense;
  // run lengths of the pin, saturating so a long sleep cannot wrap
  always @(posedge clk_sys) begin
    if (!nrst) begin
      low_cnt <= 16'h0000;
      hi_cnt <= 16'h0000;
    end else begin
      low_cnt <= activate_pin ? 16'h0000 : low_cnt + (low_cnt != 16'hFFFF);
      hi_cnt <= !activate_pin ? 16'h0000 : hi_cnt + (hi_cnt != 16'hFFFF);
    end
  end
  sequence s_active;
    active_discharge && !passive_discharge;
  endsequence
  sequence s_passive;
    passive_discharge && !active_discharge && !pump_enable && !drivers_enable;
  endsequence
  a_normal_setup: assert property (
    mode == `MODE_NORMAL && $past(mode) == `MODE_SLEEP |-> hi_cnt >= 16'h018F)
    else $error("normal mode before setup delay");
  a_sleep_delay: assert property (
    mode == `MODE_SLEEP && $past(mode) != `MODE_SLEEP |-> low_cnt >= 16'h01B7)
    else $error("sleep entered too early");
  a_sleep_reset: assert property (
    (mode == `MODE_SLEEP) [*2] |-> general_control_one == `CTRL_RESET
    && sense_config == `SENSE_RESET && !power_on_reset_n_flag)
    else $error("registers not reset in sleep");
  a_sleep_pulldown: assert property (
    !regulator_enable |-> gate_pulldown_resistor && !drivers_enable)
    else $error("gate pull-down off in sleep");
  a_frame_ignored: assert property (
    !frames_accepted && wr_other |=> $stable(general_control_one) || mode == `MODE_SLEEP)
    else $error("refused frame changed control");
  a_fs_freeze: assert property (
    (mode == `MODE_FAILSAFE) [*2] |-> general_control_one == `CTRL_RESET
    && failsafe_flag && pump_undervoltage_flag)
    else $error("fail safe state wrong");
  a_fs_write_err: assert property (
    mode == `MODE_FAILSAFE && frames_accepted && wr_other |=> serial_error_flag)
    else $error("fail safe write without error flag");
  a_clear_por: assert property (
    frames_accepted && frame_valid && frame_kind == `FK_CLEAR && frame_is_status
    |=> power_on_reset_n_flag)
    else $error("status clear left por flag low");
  a_fs_discharge: assert property (
    mode == `MODE_NORMAL && watchdog_error |-> ##[1:3] s_active ##[1:FS_MAX] s_passive)
    else $error("fail safe discharge order wrong");
endmodule
bind operating_mode_controller opmode_sva opmode_sva_i (.*);

// File: test/mcu_model.sv
/* microcontroller model: activate pin and decoded frames.
   assumes the bench calls its tasks; changes land at rising edges. */
`timescale 1ns/100ps
`include "opmode_map.vh"
module mcu_model (
  // clock
  input wire clk_sys,
  // activate pin and frame fields
  output logic activate_pin = 1'b0,
  output logic frame_valid = 1'b0,
  output logic [1:0] frame_kind = 2'h0,
  output logic frame_is_toggle = 1'b0,
  output logic frame_toggle_value = 1'b0,
  output logic frame_is_status = 1'b0,
  output logic frame_is_sense = 1'b0,
  output logic [15:0] frame_ctrl_data = 16'h0000,
  output logic [7:0] frame_sense_data = 8'h00
);
  // pin level change at an edge
  task automatic set_act(input logic v);
    @(posedge clk_sys);
    activate_pin <= v;
  endtask
  // one frame strobe; data turns over after, so stale data never matches
  task automatic send(input logic [1:0] k, input logic [2:0] f, input logic [15:0] d);
    @(posedge clk_sys);
    frame_valid <= 1'b1;
    frame_kind <= k;
    {frame_is_toggle, frame_is_status, frame_is_sense} <= f;
    frame_toggle_value <= d[0];
    frame_ctrl_data <= d;
    frame_sense_data <= d[7:0];
    @(posedge clk_sys);
    frame_valid <= 1'b0;
    frame_ctrl_data <= ~d;
    frame_sense_data <= ~d[7:0];
  endtask
  // exit sequence, optionally broken by a stray read
  task automatic leave_fs(input bit stray);
    send(`FK_CLEAR, 3'h2, 16'h0000);
    send(`FK_WRITE, 3'h4, 16'h0001);
    if (stray) send(`FK_READ, 3'h0, 16'h0000);
    send(`FK_WRITE, 3'h4, 16'h0000);
  endtask
endmodule

// File: test/operating_mode_controller_tb.sv
/* bench of the operating-mode controller with the microcontroller model.
   assumes the checker is bound from its own file. */
`timescale 1ns/100ps
`include "opmode_map.vh"
module operating_mode_controller_tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic battery_ok;
  logic logic_supply_ok;
  logic [11:0] cross_conduction_time;
  logic watchdog_error;
  logic pump_uv_event;
  wire activate_pin, frame_valid, frame_is_toggle, frame_toggle_value;
  wire frame_is_status, frame_is_sense;
  wire [1:0] frame_kind;
  wire [15:0] frame_ctrl_data, general_control_one;
  wire [7:0] frame_sense_data, sense_config;
  wire [2:0] mode;
  wire drivers_enable, active_discharge, passive_discharge, gate_pulldown_resistor;
  wire pump_enable, regulator_enable, frames_accepted, watchdog_toggle_bit;
  wire failsafe_flag, serial_error_flag, pump_undervoltage_flag, power_on_reset_n_flag;
  int n_errors = 0;
  int samples_checked = 0;
  int cct;
  int n;
  int q[$];
  int exp_ctrl;
  operating_mode_controller operating_mode_controller_i (.*);
  mcu_model mcu_model_i (.*);
  always #12.5 clk_sys = ~clk_sys;
  task automatic chk(input bit ok, input string msg);
    samples_checked++;
    if (!ok) begin
      n_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // bounded wait for a mode; n keeps the cycles spent
  task automatic wait_mode(input logic [2:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      cyc(1);
      n++;
    end
    chk(mode === m, "mode not reached");
  endtask
  task automatic wr(input logic [2:0] f, input int d);
    mcu_model_i.send(`FK_WRITE, f, 16'(d));
    cyc(1);
  endtask
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far beyond the fewer than two thousand cycles of the run
  initial begin
    #250000;
    n_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(68478));
    cct = 8 + $urandom_range(32);
    cross_conduction_time <= 12'(cct);
    battery_ok <= 1'b1;
    logic_supply_ok <= 1'b1;
    watchdog_error <= 1'b0;
    pump_uv_event <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    chk(mode === `MODE_SLEEP && gate_pulldown_resistor === 1'b1, "reset state");
    mcu_model_i.set_act(1'b1);
    wait_mode(`MODE_NORMAL, 420);
    chk(n >= 400, "setup too short");
    chk(drivers_enable === 1'b1 && power_on_reset_n_flag === 1'b0, "normal");
    repeat (4) begin
      q.push_back($urandom_range(16'hFFFF));
      wr(3'h0, q[$]);
      exp_ctrl = q.pop_front();
      chk(general_control_one === 16'(exp_ctrl), "ctrl write");
    end
    @(posedge clk_sys) battery_ok <= 1'b0;
    @(posedge clk_sys) pump_uv_event <= 1'b1;
    @(posedge clk_sys) pump_uv_event <= 1'b0;
    cyc(4);
    battery_ok <= 1'b1;
    chk(general_control_one === 16'(exp_ctrl) && drivers_enable === 1'b0, "battery drop");
    mcu_model_i.send(`FK_CLEAR, 3'h2, 16'h0000);
    cyc(1);
    chk(power_on_reset_n_flag === 1'b1 && pump_undervoltage_flag === 1'b0, "clear");
    @(posedge clk_sys) logic_supply_ok <= 1'b0;
    cyc(2);
    chk(drivers_enable === 1'b0, "logic supply low");
    @(posedge clk_sys) logic_supply_ok <= 1'b1;
    cyc(2);
    chk(drivers_enable === 1'b1, "logic supply back");
    mcu_model_i.set_act(1'b0);
    cyc(100);
    mcu_model_i.set_act(1'b1);
    cyc(300);
    chk(mode === `MODE_NORMAL && general_control_one === 16'(exp_ctrl), "glitch");
    mcu_model_i.set_act(1'b0);
    cyc(340);
    chk(active_discharge === 1'b1 && mode === `MODE_NORMAL, "turn-off delay");
    chk(frames_accepted === 1'b0, "frames closed in delay");
    wr(3'h0, 16'h5A5A);
    chk(general_control_one === 16'(exp_ctrl), "frame in delay");
    wait_mode(`MODE_SLEEP, 200);
    chk(n + 343 >= 440 + cct && n + 343 <= 450 + cct, "sleep delay");
    cyc(1);
    chk(general_control_one === `CTRL_RESET && drivers_enable === 1'b0, "sleep");
    chk(regulator_enable === 1'b0 && gate_pulldown_resistor === 1'b1, "sleep pins");
    mcu_model_i.set_act(1'b1);
    wait_mode(`MODE_NORMAL, 420);
    wr(3'h0, 16'h00F0);
    @(posedge clk_sys) watchdog_error <= 1'b1;
    @(posedge clk_sys) watchdog_error <= 1'b0;
    wait_mode(`MODE_FAILSAFE, 5);
    chk(failsafe_flag === 1'b1 && active_discharge === 1'b1, "fs entry");
    chk(general_control_one === `CTRL_RESET, "fs freeze");
    cyc(60);
    chk(passive_discharge === 1'b1 && pump_enable === 1'b0, "passive");
    mcu_model_i.send(`FK_READ, 3'h0, 16'h0000);
    cyc(1);
    chk(serial_error_flag === 1'b0, "fs read");
    wr(3'h1, 16'h00A5);
    chk(sense_config === 8'hA5, "fs sense");
    wr(3'h4, 16'h0001);
    chk(watchdog_toggle_bit === 1'b1 && serial_error_flag === 1'b0, "fs toggle");
    wr(3'h0, 16'h1234);
    chk(serial_error_flag === 1'b1 && general_control_one === `CTRL_RESET, "fs wr");
    mcu_model_i.send(`FK_CLEAR, 3'h2, 16'h0000);
    cyc(1);
    chk(failsafe_flag === 1'b1 && pump_undervoltage_flag === 1'b1, "fs clear");
    mcu_model_i.leave_fs(1'b1);
    cyc(2);
    chk(mode === `MODE_FAILSAFE, "stray frame");
    mcu_model_i.leave_fs(1'b0);
    wait_mode(`MODE_NORMAL, 5);
    chk(drivers_enable === 1'b0 && pump_undervoltage_flag === 1'b1, "exit");
    mcu_model_i.send(`FK_CLEAR, 3'h2, 16'h0000);
    cyc(2);
    chk(drivers_enable === 1'b1 && pump_undervoltage_flag === 1'b0, "re-enable");
    stop_test();
  end
endmodule
